/* File: shared/qdc_pkg.sv */
// constants and carrier types for the quad converter register bank
package qdc_pkg;
    // sizes
    localparam int NUM_CH   = 4;
    localparam int FRAME_W  = 24;
    localparam int DATA_W   = 16;
    localparam int SLEW_W   = 13;
    localparam int BITCNT_W = 5;
    localparam logic [BITCNT_W-1:0] FRAME_BITS = 5'h18;

    // register-select codes carried in the command word
    localparam logic [2:0] SEL_CODE     = 3'h0;
    localparam logic [2:0] SEL_GAIN     = 3'h2;
    localparam logic [2:0] SEL_GAIN_ALL = 3'h3;
    localparam logic [2:0] SEL_OFFS     = 3'h4;
    localparam logic [2:0] SEL_OFFS_ALL = 3'h5;
    localparam logic [2:0] SEL_CLEAR    = 3'h6;
    localparam logic [2:0] SEL_CTRL     = 3'h7;

    // control-register sub-select in the top three payload bits
    localparam logic [2:0] CSEL_SLEW = 3'h0;
    localparam logic [2:0] CSEL_MAIN = 3'h1;
    localparam logic [2:0] CSEL_CHAN = 3'h2;
    localparam logic [2:0] CSEL_CONV = 3'h3;
    localparam logic [2:0] CSEL_SOFT = 3'h4;

    // software register keys (values are arbitrary)
    localparam logic [SLEW_W-1:0] SOFT_RESET_KEY = 13'h0555;
    localparam logic [SLEW_W-1:0] SOFT_KICK_KEY  = 13'h0aaa;

    // code handling and reset values
    localparam logic [DATA_W-1:0] CODE_MASK_12 = 16'hfff0;
    localparam logic [DATA_W-1:0] CODE_MASK_16 = 16'hffff;
    localparam logic [DATA_W-1:0] CODE_RESET   = 16'h0000;
    localparam logic [DATA_W-1:0] CLEAR_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] GAIN_RESET   = 16'hffff;
    localparam logic [DATA_W-1:0] OFFS_RESET   = 16'h8000;
    localparam logic [SLEW_W-1:0] SLEW_RESET   = 13'h0000;
    localparam logic [2:0]        RANGE_0_5V   = 3'h0;

    // 24-bit command word, msb first on the wire
    typedef struct packed {
        logic              rw;
        logic [1:0]        chip_address_field;
        logic [2:0]        register_select_field;
        logic [1:0]        channel;
        logic [DATA_W-1:0] data;
    } qdc_frame_t;

    // per-channel control, payload bits 7:0
    typedef struct packed {
        logic       converter_power_enable;
        logic       output_drive_enable;
        logic       overrange_en;
        logic       clear_en;
        logic       ext_sense;
        logic [2:0] range;
    } qdc_chan_ctrl_t;

    // main control, payload bits 5:0
    typedef struct packed {
        logic [1:0] wd_timeout;
        logic       wd_en;
        logic       all_power;
        logic       all_output_drive_enable;
        logic       status_readback;
    } qdc_main_t;

    // converter control, payload bits 5:0
    typedef struct packed {
        logic [1:0] freq;
        logic [1:0] phase;
        logic [1:0] max_v;
    } qdc_conv_t;

    localparam qdc_chan_ctrl_t CHAN_RESET = '{
        converter_power_enable: 1'b0, output_drive_enable: 1'b0,
        overrange_en: 1'b0, clear_en: 1'b0, ext_sense: 1'b0,
        range: RANGE_0_5V};
    localparam qdc_main_t MAIN_RESET = '{
        wd_timeout: 2'h0, wd_en: 1'b0, all_power: 1'b0,
        all_output_drive_enable: 1'b0, status_readback: 1'b0};
    localparam qdc_conv_t CONV_RESET = '{
        freq: 2'h0, phase: 2'h0, max_v: 2'h0};
endpackage

/* File: verilog/qdc_serial_rx.sv */
// three-wire serial receiver: synchronises pins, assembles 24-bit words
`timescale 1ns/1ps
`default_nettype none
module qdc_serial_rx
    import qdc_pkg::*;
(
    // clock, reset, enable
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic       ce_in,
    // serial pins
    input  wire logic       sclk_in,
    input  wire logic       frame_n_in,
    input  wire logic       sdin_in,
    // assembled word
    output qdc_frame_t      frame_out,
    output logic            frame_valid_out
);
    logic [2:0]         meta;
    logic [2:0]         sync;
    logic               sclk_prev;
    logic               frame_n_prev;
    logic [FRAME_W-1:0] shift;
    logic [BITCNT_W-1:0] count;
    logic               overrun;

    // two-flop synchronisers for sclk, frame, data
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            meta <= 3'h7;
            sync <= 3'h7;
        end else if (ce_in) begin
            meta <= {sclk_in, frame_n_in, sdin_in};
            sync <= meta;
        end
    end

    // edge history of synchronised sclk and frame
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sclk_prev    <= 1'b1;
            frame_n_prev <= 1'b1;
        end else if (ce_in) begin
            sclk_prev    <= sync[2];
            frame_n_prev <= sync[1];
        end
    end

    // shift on falling sclk while frame low, msb first
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            shift   <= '0;
            count   <= '0;
            overrun <= 1'b0;
        end else if (ce_in) begin
            if (sync[1] && !frame_n_prev) begin
                count   <= '0;
                overrun <= 1'b0;
            end else if (!sync[1] && sclk_prev && !sync[2]) begin
                shift <= {shift[FRAME_W-2:0], sync[0]};
                if (count == FRAME_BITS) begin
                    overrun <= 1'b1;
                end else begin
                    count <= count + 5'h01;
                end
            end
        end
    end

    // word taken on rising frame if exactly 24 bits arrived
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            frame_out       <= '0;
            frame_valid_out <= 1'b0;
        end else if (ce_in) begin
            frame_valid_out <= 1'b0;
            if (sync[1] && !frame_n_prev && count == FRAME_BITS
                    && !overrun) begin
                frame_out       <= qdc_frame_t'(shift);
                frame_valid_out <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/qdc_reg_bank.sv */
// register bank and enable logic of the quad output converter
`timescale 1ns/1ps
`default_nettype none
module qdc_reg_bank
    import qdc_pkg::*;
(
    // clock, reset, enable
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic       ce_in,
    // serial link
    input  wire logic       sclk_in,
    input  wire logic       frame_n_in,
    input  wire logic       sdin_in,
    // straps and clear pin
    input  wire logic [1:0] chip_addr_in,
    input  wire logic       variant_12bit_in,
    input  wire logic       clear_in,
    // per-channel results
    output logic [DATA_W-1:0]   chan_code_out [NUM_CH],
    output logic [DATA_W-1:0]   chan_gain_out [NUM_CH],
    output logic [DATA_W-1:0]   chan_offset_out [NUM_CH],
    output logic [SLEW_W-1:0]   chan_slew_out [NUM_CH],
    output qdc_chan_ctrl_t      chan_ctrl_out [NUM_CH],
    output logic [NUM_CH-1:0]   drive_en_out,
    output logic [NUM_CH-1:0]   power_en_out,
    output logic [NUM_CH-1:0]   calibrate_out,
    // global settings and events
    output qdc_main_t           main_ctrl_out,
    output qdc_conv_t           conv_ctrl_out,
    output logic                wd_kick_out,
    output logic                soft_reset_out
);
    qdc_frame_t          frame;
    logic                frame_valid;
    logic [3:0]          pin_meta;
    logic [3:0]          pin_sync;
    logic                wr;
    logic                ctrl_wr;
    logic                rst_all;
    logic [DATA_W-1:0]   code_mask;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   clear_value [NUM_CH];

    // serial word assembly
    qdc_serial_rx u_rx (
        .mclk_in         (mclk_in),
        .reset_in        (reset_in),
        .ce_in           (ce_in),
        .sclk_in         (sclk_in),
        .frame_n_in      (frame_n_in),
        .sdin_in         (sdin_in),
        .frame_out       (frame),
        .frame_valid_out (frame_valid)
    );

    // straps and clear pin through two flops
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else if (ce_in) begin
            pin_meta <= {chip_addr_in, variant_12bit_in, clear_in};
            pin_sync <= pin_meta;
        end
    end

    // write decode: write bit low and chip address matches
    assign wr = frame_valid && !frame.rw
                && frame.chip_address_field == pin_sync[3:2];
    assign ctrl_wr = wr && frame.register_select_field == SEL_CTRL;
    assign code_mask = pin_sync[1] ? CODE_MASK_12 : CODE_MASK_16;
    assign wdata = frame.data & code_mask;
    assign rst_all = reset_in || soft_reset_out;

    // software register: reset or watchdog kick pulse
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            soft_reset_out <= 1'b0;
            wd_kick_out    <= 1'b0;
        end else if (ce_in) begin
            soft_reset_out <= ctrl_wr
                && frame.data[15:13] == CSEL_SOFT
                && frame.data[SLEW_W-1:0] == SOFT_RESET_KEY;
            wd_kick_out <= ctrl_wr
                && frame.data[15:13] == CSEL_SOFT
                && frame.data[SLEW_W-1:0] == SOFT_KICK_KEY;
        end
    end

    // global main and converter control
    always_ff @(posedge mclk_in) begin
        if (rst_all) begin
            main_ctrl_out <= MAIN_RESET;
            conv_ctrl_out <= CONV_RESET;
        end else if (ce_in && ctrl_wr) begin
            if (frame.data[15:13] == CSEL_MAIN) begin
                main_ctrl_out <= qdc_main_t'(frame.data[5:0]);
            end
            // kept across range changes until rewritten
            if (frame.data[15:13] == CSEL_CONV) begin
                conv_ctrl_out <= qdc_conv_t'(frame.data[5:0]);
            end
        end
    end

    // one copy of the per-channel registers for each channel
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
            logic hit;
            logic code_wr;
            assign hit = frame.channel == 2'(ch);
            assign code_wr = wr && hit
                && frame.register_select_field == SEL_CODE;

            // output code, clear load wins over a same-cycle write
            always_ff @(posedge mclk_in) begin
                if (rst_all) begin
                    chan_code_out[ch] <= CODE_RESET;
                    calibrate_out[ch] <= 1'b0;
                end else if (ce_in) begin
                    calibrate_out[ch] <= code_wr;
                    if (pin_sync[0] && chan_ctrl_out[ch].clear_en) begin
                        chan_code_out[ch] <= clear_value[ch];
                    end else if (code_wr) begin
                        chan_code_out[ch] <= wdata;
                    end
                end
            end

            // trim and clear registers, broadcast forms hit all
            always_ff @(posedge mclk_in) begin
                if (rst_all) begin
                    chan_gain_out[ch]   <= GAIN_RESET;
                    chan_offset_out[ch] <= OFFS_RESET;
                    clear_value[ch]     <= CLEAR_RESET;
                end else if (ce_in && wr) begin
                    if ((hit && frame.register_select_field == SEL_GAIN)
                        || frame.register_select_field == SEL_GAIN_ALL) begin
                        chan_gain_out[ch] <= wdata;
                    end
                    if ((hit && frame.register_select_field == SEL_OFFS)
                        || frame.register_select_field == SEL_OFFS_ALL) begin
                        chan_offset_out[ch] <= wdata;
                    end
                    if (hit && frame.register_select_field == SEL_CLEAR) begin
                        clear_value[ch] <= wdata;
                    end
                end
            end

            // slew rate and channel control
            always_ff @(posedge mclk_in) begin
                if (rst_all) begin
                    chan_slew_out[ch] <= SLEW_RESET;
                    chan_ctrl_out[ch] <= CHAN_RESET;
                end else if (ce_in && ctrl_wr && hit) begin
                    if (frame.data[15:13] == CSEL_SLEW) begin
                        chan_slew_out[ch] <= frame.data[SLEW_W-1:0];
                    end
                    if (frame.data[15:13] == CSEL_CHAN) begin
                        chan_ctrl_out[ch] <=
                            qdc_chan_ctrl_t'(frame.data[7:0]);
                    end
                end
            end

            // drive and supply enables, channel or global
            always_ff @(posedge mclk_in) begin
                if (rst_all) begin
                    drive_en_out[ch] <= 1'b0;
                    power_en_out[ch] <= 1'b0;
                end else if (ce_in) begin
                    drive_en_out[ch] <= chan_ctrl_out[ch].output_drive_enable
                        || main_ctrl_out.all_output_drive_enable;
                    power_en_out[ch] <=
                        chan_ctrl_out[ch].converter_power_enable
                        || main_ctrl_out.all_power;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* File: tb/qdc_reg_bank_properties.sv */
// port-level assertions for the quad converter register bank
`timescale 1ns/1ps
`default_nettype none
module qdc_reg_bank_properties
    import qdc_pkg::*;
(
    // clock, reset, link
    input wire logic              mclk_in,
    input wire logic              reset_in,
    input wire logic              frame_n_in,
    // observed results
    input wire logic [DATA_W-1:0] chan_code_out [NUM_CH],
    input wire logic [DATA_W-1:0] chan_gain_out [NUM_CH],
    input wire logic [SLEW_W-1:0] chan_slew_out [NUM_CH],
    input wire qdc_chan_ctrl_t    chan_ctrl_out [NUM_CH],
    input wire logic [NUM_CH-1:0] drive_en_out,
    input wire logic [NUM_CH-1:0] power_en_out,
    input wire logic [NUM_CH-1:0] calibrate_out,
    input wire qdc_main_t         main_ctrl_out,
    input wire qdc_conv_t         conv_ctrl_out,
    input wire logic              wd_kick_out,
    input wire logic              soft_reset_out
);
    logic              rst_d;
    logic [NUM_CH-1:0] output_drive_enable_v;
    logic [NUM_CH-1:0] power_v;
    // any reset applied at the previous edge
    always_ff @(posedge mclk_in) begin
        rst_d <= reset_in || soft_reset_out;
    end
    // per-channel enable bits as vectors
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            output_drive_enable_v[i] = chan_ctrl_out[i].output_drive_enable;
            power_v[i] = chan_ctrl_out[i].converter_power_enable;
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    a_reset_defaults: assert property ($fell(reset_in) |->
        chan_ctrl_out[3].range == RANGE_0_5V && chan_code_out[2] == 16'h0)
        else $error("defaults missing after reset");
    a_soft_defaults: assert property (soft_reset_out |=>
        chan_gain_out[1] == GAIN_RESET && conv_ctrl_out == CONV_RESET)
        else $error("defaults missing after software reset");
    a_kick_pulse: assert property (wd_kick_out |=> !wd_kick_out)
        else $error("keep-alive pulse too long");
    a_cal_pulse: assert property (
        calibrate_out != 0 |=> calibrate_out == 0)
        else $error("calibrate pulse too long");
    a_cal_onehot: assert property ($onehot0(calibrate_out))
        else $error("calibrate on several channels");
    a_cal_frame: assert property (
        calibrate_out != 0 |-> $past(frame_n_in, 2))
        else $error("calibrate without a finished word");
    a_drive_follow: assert property (!rst_d |-> drive_en_out ==
        $past(output_drive_enable_v | {NUM_CH{main_ctrl_out.all_output_drive_enable}}))
        else $error("output drive not following enables");
    a_power_follow: assert property (!rst_d |-> power_en_out ==
        $past(power_v | {NUM_CH{main_ctrl_out.all_power}}))
        else $error("supply enable not following enables");
    a_conv_kept: assert property ($changed(conv_ctrl_out) |->
        rst_d || $past(frame_n_in, 2))
        else $error("converter settings changed without a write");
    a_slew_kept: assert property ($changed(chan_slew_out[0]) |->
        rst_d || $past(frame_n_in, 2))
        else $error("slew changed without a write");
endmodule
`default_nettype wire

/* File: tb/qdc_host_model.sv */
// host serial master model for the three-wire link
`timescale 1ns/1ps
`default_nettype none
module qdc_host_model
    import qdc_pkg::*;
(
    // serial pins
    output var logic sclk_out,
    output var logic frame_n_out,
    output var logic sdin_out
);
    // clock stands high and frame released between words
    initial begin
        sclk_out    = 1'b1;
        frame_n_out = 1'b1;
        sdin_out    = 1'b0;
    end
    // top n bits msb first, data set while clock high
    task automatic send(input qdc_frame_t w, input int n);
        frame_n_out = 1'b0;
        #130;
        for (int i = 0; i < n; i++) begin
            sdin_out = w[FRAME_W-1-i];
            #200 sclk_out = 1'b0;
            #200 sclk_out = 1'b1;
        end
        #130 frame_n_out = 1'b1;
        sdin_out = ~sdin_out;
        #900;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the quad converter register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import qdc_pkg::*;
;
    localparam logic [1:0] CHIP = 2'h2;
    logic mclk_in, reset_in, ce_in, sclk_in, frame_n_in, sdin_in;
    logic [1:0] chip_addr_in;
    logic variant_12bit_in, clear_in, wd_kick_out, soft_reset_out;
    logic [DATA_W-1:0] chan_code_out [NUM_CH];
    logic [DATA_W-1:0] chan_gain_out [NUM_CH];
    logic [DATA_W-1:0] chan_offset_out [NUM_CH];
    logic [SLEW_W-1:0] chan_slew_out [NUM_CH];
    qdc_chan_ctrl_t    chan_ctrl_out [NUM_CH];
    logic [NUM_CH-1:0] drive_en_out, power_en_out, calibrate_out;
    qdc_main_t         main_ctrl_out;
    qdc_conv_t         conv_ctrl_out;
    int err_count, checks_done, kick_cnt, srst_cnt;
    int cal_cnt [NUM_CH];
    qdc_frame_t f;
    qdc_host_model host_i (.sclk_out(sclk_in), .frame_n_out(frame_n_in),
        .sdin_out(sdin_in));
    qdc_reg_bank qdc_reg_bank_i (.mclk_in(mclk_in), .reset_in(reset_in),
        .ce_in(ce_in), .sclk_in(sclk_in), .frame_n_in(frame_n_in),
        .sdin_in(sdin_in), .chip_addr_in(chip_addr_in),
        .variant_12bit_in(variant_12bit_in), .clear_in(clear_in),
        .chan_code_out(chan_code_out), .chan_gain_out(chan_gain_out),
        .chan_offset_out(chan_offset_out), .chan_slew_out(chan_slew_out),
        .chan_ctrl_out(chan_ctrl_out), .drive_en_out(drive_en_out),
        .power_en_out(power_en_out), .calibrate_out(calibrate_out),
        .main_ctrl_out(main_ctrl_out), .conv_ctrl_out(conv_ctrl_out),
        .wd_kick_out(wd_kick_out), .soft_reset_out(soft_reset_out));
    // clock and pulse counters
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    // pulses counted mid-cycle, where they have settled
    always @(negedge mclk_in) begin
        kick_cnt += int'(wd_kick_out);
        srst_cnt += int'(soft_reset_out);
        for (int i = 0; i < NUM_CH; i++) cal_cnt[i] += int'(calibrate_out[i]);
    end
    function automatic qdc_frame_t cmd(logic [2:0] s, int c, logic [15:0] d);
        return {1'b0, CHIP, s, 2'(c), d};
    endfunction
    task automatic wr(input logic [2:0] s, input int c, input logic [15:0] d);
        host_i.send(cmd(s, c, d), FRAME_W);
    endtask
    task automatic ctl(input logic [2:0] s, input int c, input logic [12:0] v);
        wr(SEL_CTRL, c, {s, v});
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // hang guard
    initial begin
        #3ms err_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        {reset_in, ce_in, chip_addr_in} = {2'b11, CHIP};
        {variant_12bit_in, clear_in} = 2'b00;
        repeat (3) @(negedge mclk_in);
        reset_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        for (int i = 0; i < NUM_CH; i++) begin
            chk(chan_ctrl_out[i], CHAN_RESET);
            chk(chan_code_out[i], CODE_RESET);
            chk(chan_gain_out[i], GAIN_RESET);
            chk(chan_offset_out[i], OFFS_RESET);
        end
        wr(SEL_GAIN, 1, 16'h1234);
        chk(chan_gain_out[1], 16'h1234);
        ctl(CSEL_SOFT, 0, SOFT_RESET_KEY);
        chk(chan_gain_out[1], GAIN_RESET);
        ctl(CSEL_SOFT, 0, SOFT_KICK_KEY);
        ctl(CSEL_SOFT, 0, 13'h0123);
        chk(16'(kick_cnt + 16 * srst_cnt), 16'h0011);
        ctl(CSEL_CONV, 0, 13'h002d);
        chk(conv_ctrl_out, 6'h2d);
        ctl(CSEL_MAIN, 0, 13'h0006);
        chk({drive_en_out, power_en_out}, 8'hff);
        ctl(CSEL_MAIN, 0, 13'h0039);
        chk(main_ctrl_out, 6'h39);
        chk(drive_en_out, 4'h0);
        // enable sequence on every channel, one range each
        for (int i = 0; i < NUM_CH; i++) begin
            ctl(CSEL_CHAN, i, 13'(8'h80 + i));
            chk({power_en_out[i], drive_en_out[i]}, 2'b10);
            wr(SEL_CODE, i, 16'(16'h1235 + i));
            chk(16'(cal_cnt[i]), 16'h1);
            ctl(CSEL_CHAN, i, 13'(8'hc0 + i));
            chk(drive_en_out[i], 1'b1);
        end
        for (int i = 0; i < NUM_CH; i++) begin
            chk(chan_code_out[i], 16'(16'h1235 + i));
            chk(chan_ctrl_out[i], 8'(8'hc0 + i));
            wr(SEL_GAIN, i, 16'(16'h4440 + i));
            wr(SEL_OFFS, i, 16'(16'h5550 + i));
            wr(SEL_CLEAR, i, 16'(16'h6660 + i));
            ctl(CSEL_SLEW, i, 13'(13'h0100 + i));
        end
        for (int i = 0; i < NUM_CH; i++) begin
            chk(chan_gain_out[i], 16'(16'h4440 + i));
            chk(chan_offset_out[i], 16'(16'h5550 + i));
            chk(chan_slew_out[i], 13'(13'h0100 + i));
        end
        wr(SEL_GAIN_ALL, 0, 16'h7777);
        wr(SEL_OFFS_ALL, 0, 16'h8889);
        for (int i = 0; i < NUM_CH; i++)
            chk(chan_gain_out[i] ^ chan_offset_out[i], 16'hfffe);
        // twelve-bit variant drops the low nibble
        @(negedge mclk_in) variant_12bit_in = 1'b1;
        wr(SEL_CODE, 0, 16'habcd);
        wr(SEL_GAIN, 3, 16'h123f);
        chk(chan_code_out[0], 16'habc0);
        chk(chan_gain_out[3], 16'h1230);
        @(negedge mclk_in) variant_12bit_in = 1'b0;
        // read, wrong chip and short words are ignored
        f = cmd(SEL_CODE, 1, 16'hdead);
        f.rw = 1'b1;
        host_i.send(f, FRAME_W);
        f = {1'b0, ~CHIP, f[20:0]};
        host_i.send(f, FRAME_W);
        host_i.send(cmd(SEL_CODE, 1, 16'hdead), 23);
        chk(chan_code_out[1], 16'h1236);
        // clear pin loads clear code on enabled channel only
        ctl(CSEL_CHAN, 2, 13'h00d2);
        @(negedge mclk_in) clear_in = 1'b1;
        repeat (6) @(negedge mclk_in);
        chk(chan_code_out[2], 16'h6662);
        chk(chan_code_out[3], 16'h1238);
        clear_in = 1'b0;
        // clock enable low freezes the link and every register
        @(negedge mclk_in) ce_in = 1'b0;
        wr(SEL_GAIN, 0, 16'h0f0f);
        @(negedge mclk_in) ce_in = 1'b1;
        chk(chan_gain_out[0], 16'h7777);
        // range change on channel 0, parked at zero first
        wr(SEL_CODE, 0, 16'h0000);
        ctl(CSEL_CHAN, 0, 13'h0083);
        chk(drive_en_out[0], 1'b0);
        wr(SEL_CODE, 0, 16'h8000);
        ctl(CSEL_CHAN, 0, 13'h00c3);
        chk({drive_en_out[0], conv_ctrl_out}, 7'h6d);
        wrap_up();
    end
endmodule
bind qdc_reg_bank qdc_reg_bank_properties props_i (.mclk_in(mclk_in),
    .reset_in(reset_in), .frame_n_in(frame_n_in),
    .chan_code_out(chan_code_out), .chan_gain_out(chan_gain_out),
    .chan_slew_out(chan_slew_out), .chan_ctrl_out(chan_ctrl_out),
    .drive_en_out(drive_en_out), .power_en_out(power_en_out),
    .calibrate_out(calibrate_out), .main_ctrl_out(main_ctrl_out),
    .conv_ctrl_out(conv_ctrl_out), .wd_kick_out(wd_kick_out),
    .soft_reset_out(soft_reset_out));
`default_nettype wire
